//--- core/serdes_link_pkg.sv
// Purpose: Shared constants for the serial link lock and sync logic
// Assumes: One 40 MHz core clock; the link is sampled as a plain input
// Notes: Frame is start bit, 10 data bits, stop bit
package serdes_link_pkg;
  localparam int WORD_W = 10;
  localparam int FRAME_W = 12;
  localparam int BIT_CYCLES = 4;
  localparam int SYNC_MIN_SYMBOLS = 1024;
  localparam int LOSS_COUNT = 4;
  localparam int LOCK_GOOD_WORDS = 4;
  localparam int SYMBOL_CNT_W = 11;
  localparam logic [WORD_W-1:0] SYNC_PATTERN = 10'h01f;
  localparam logic START_BIT = 1'b1;
  localparam logic STOP_BIT = 1'b0;
endpackage

//--- core/word_buffer.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Same clock on both sides
// Notes: Output data and valid come straight from flip-flops
`timescale 1ns/1ps
module word_buffer #(
  parameter int WIDTH = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] spare_r;
  logic spareValid_r;
  logic outValid_r;
  logic [WIDTH-1:0] outData_r;
  wire takeIn = inValid && inReady;
  wire takeOut = outValid_r && outReady;

  assign inReady = !spareValid_r;
  assign outValid = outValid_r;
  assign outData = outData_r;

  // Head register and spare slot
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      outValid_r <= 1'b0;
      outData_r <= '0;
      spareValid_r <= 1'b0;
      spare_r <= '0;
    end
    else if (!outValid_r || takeOut)
    begin
      outValid_r <= spareValid_r || takeIn;
      outData_r <= spareValid_r ? spare_r : inData;
      spareValid_r <= spareValid_r && takeIn;
      if (spareValid_r)
        spare_r <= inData;
    end
    else if (takeIn)
    begin
      spareValid_r <= 1'b1;
      spare_r <= inData;
    end
  end
endmodule

//--- core/serdes_link_lock_sync.sv
// Purpose: Serializer framing and deserializer lock tracking for one link
// Assumes: Link line sampled by clk after two flip-flops
// Notes: Bit period is BIT_CYCLES core cycles in both directions
// Operation
// - Each 10-bit word framed by two clock bits
// - Receiver searches only while reference clock runs
// - Lock indicator high when unlocked, low locked
// - Parallel outputs released only after lock
// - Either sync request sends sync patterns
// - Random data alone can achieve lock
// - Output data valid while lock indicator low
// - Four consecutive bad clock bits drop lock
// - Up to three prior words may be corrupt
// - Relock by sync patterns or random lock
// - Transmitter high impedance forces loss of lock
// - At least 1024 sync symbols per request
// - Serial output off while enable low
// - Power down stops transmitter and floats output
// - Edge select picks rising or falling capture
`timescale 1ns/1ps
module serdes_link_lock_sync
  import serdes_link_pkg::*;
#(
  parameter int LOSS_LIMIT = LOSS_COUNT,
  parameter int GOOD_LIMIT = LOCK_GOOD_WORDS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Transmit parallel side
  input wire logic transmitWordClock,
  input wire logic captureEdgeSelect,
  input wire logic [WORD_W-1:0] txWord,
  input wire logic syncRequestA,
  input wire logic syncRequestB,
  input wire logic serialOutputEnable,
  input wire logic powerDown_n,
  // Transmit serial side
  output logic serialOutPos,
  output logic serialOutNeg,
  output logic serialOutOe,
  // Receive serial side
  input wire logic serialInPos,
  input wire logic serialInNeg,
  input wire logic receiverReferenceClock,
  // Receive parallel side
  output logic [WORD_W-1:0] parallelOutputWord,
  output logic parallelOutputOe,
  output logic parallelOutputValid,
  input wire logic parallelOutputReady,
  output logic lock_n
);
  // Synchronisers for pins from outside the clock domain
  logic [1:0] wclkSync_r, refSync_r, rxPosSync_r, rxNegSync_r;
  logic wclkPrev_r, refPrev_r, rxPrev_r;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wclkSync_r <= '0;
      refSync_r <= '0;
      rxPosSync_r <= '0;
      rxNegSync_r <= '0;
      wclkPrev_r <= 1'b0;
      refPrev_r <= 1'b0;
      rxPrev_r <= 1'b0;
    end
    else
    begin
      wclkSync_r <= {wclkSync_r[0], transmitWordClock};
      refSync_r <= {refSync_r[0], receiverReferenceClock};
      rxPosSync_r <= {rxPosSync_r[0], serialInPos};
      rxNegSync_r <= {rxNegSync_r[0], serialInNeg};
      wclkPrev_r <= wclkSync_r[1];
      refPrev_r <= refSync_r[1];
      rxPrev_r <= rxPosSync_r[1];
    end
  end

  // Capture edge chosen by edge select
  wire wclkRise = wclkSync_r[1] && !wclkPrev_r;
  wire wclkFall = !wclkSync_r[1] && wclkPrev_r;
  wire captureEdge = captureEdgeSelect ? wclkRise : wclkFall;
  wire syncAny = syncRequestA || syncRequestB;
  wire txActive = powerDown_n && serialOutputEnable;

  // Parallel capture register
  logic [WORD_W-1:0] txHold_r;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      txHold_r <= '0;
    else if (captureEdge)
      txHold_r <= txWord;
  end

  // Serializer bit timing
  logic [1:0] txTick_r;
  logic [3:0] txBit_r;
  logic [FRAME_W-1:0] txShift_r;
  logic [SYMBOL_CNT_W-1:0] syncLeft_r;
  wire txBitEnd = (txTick_r == 2'(BIT_CYCLES - 1));
  wire txFrameEnd = txBitEnd && (txBit_r == 4'(FRAME_W - 1));
  wire sendSync = syncAny || (syncLeft_r != '0);
  wire syncReload = syncAny && (syncLeft_r == '0 ||
    (txFrameEnd && syncLeft_r == SYMBOL_CNT_W'(1)));
  wire [WORD_W-1:0] txPayload = sendSync ? SYNC_PATTERN : txHold_r;
  wire [FRAME_W-1:0] txFrame = {STOP_BIT, txPayload, START_BIT};

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      txTick_r <= '0;
      txBit_r <= '0;
      txShift_r <= '0;
      syncLeft_r <= '0;
    end
    else if (!powerDown_n)
    begin
      txTick_r <= '0;
      txBit_r <= '0;
      txShift_r <= '0;
      syncLeft_r <= '0;
    end
    else
    begin
      txTick_r <= txTick_r + 2'd1;
      // A request of any length loads a full run of sync frames
      if (syncReload)
        syncLeft_r <= SYMBOL_CNT_W'(SYNC_MIN_SYMBOLS);
      else if (txFrameEnd && syncLeft_r != '0)
        syncLeft_r <= syncLeft_r - 1'b1;
      if (txBitEnd)
      begin
        if (txFrameEnd)
        begin
          txBit_r <= '0;
          txShift_r <= txFrame;
        end
        else
        begin
          txBit_r <= txBit_r + 4'd1;
          txShift_r <= {1'b0, txShift_r[FRAME_W-1:1]};
        end
      end
    end
  end

  // Serial outputs registered, driven only when enabled
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      serialOutPos <= 1'b0;
      serialOutNeg <= 1'b1;
      serialOutOe <= 1'b0;
    end
    else
    begin
      serialOutPos <= txShift_r[0];
      serialOutNeg <= !txShift_r[0];
      serialOutOe <= txActive;
    end
  end

  // Receive side: reference clock watchdog
  logic [3:0] refIdle_r;
  wire refEdge = refSync_r[1] ^ refPrev_r;
  wire refRunning = (refIdle_r != 4'hf);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      refIdle_r <= 4'hf;
    else if (refEdge)
      refIdle_r <= '0;
    else if (refRunning)
      refIdle_r <= refIdle_r + 4'd1;
  end

  // Line activity: a floating line shows both legs equal
  wire lineDriven = rxPosSync_r[1] ^ rxNegSync_r[1];
  wire rxBit = rxPosSync_r[1];

  // Deserializer frame receiver
  logic [1:0] rxTick_r;
  logic [3:0] rxBit_r;
  logic [FRAME_W-1:0] rxShift_r;
  logic rxFraming_r;
  wire rxStartEdge = rxBit && !rxPrev_r && !rxFraming_r;
  wire rxSample = rxFraming_r && (rxTick_r == 2'(BIT_CYCLES / 2));
  wire rxLast = rxSample && (rxBit_r == 4'(FRAME_W - 1));
  wire [FRAME_W-1:0] rxFrame = {rxBit, rxShift_r[FRAME_W-1:1]};
  wire clockBitsOk = rxFrame[0] == START_BIT &&
                     rxFrame[FRAME_W-1] == STOP_BIT;
  wire rxWordDone = rxLast && lineDriven;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rxTick_r <= '0;
      rxBit_r <= '0;
      rxShift_r <= '0;
      rxFraming_r <= 1'b0;
    end
    else if (!refRunning)
      rxFraming_r <= 1'b0;
    else if (rxStartEdge)
    begin
      rxFraming_r <= 1'b1;
      rxTick_r <= 2'd1;
      rxBit_r <= '0;
    end
    else if (rxFraming_r)
    begin
      rxTick_r <= rxTick_r + 2'd1;
      if (rxSample)
      begin
        rxShift_r <= rxFrame;
        rxBit_r <= rxBit_r + 4'd1;
        if (rxLast)
          rxFraming_r <= 1'b0;
      end
    end
  end

  // Lock tracking: good words build lock, bad ones tear it down
  logic locked_r;
  logic [2:0] badCnt_r, goodCnt_r;
  wire lineDrop = !lineDriven && rxSample;
  wire badWord = rxLast && (!clockBitsOk || !lineDriven);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      locked_r <= 1'b0;
      badCnt_r <= '0;
      goodCnt_r <= '0;
    end
    else if (!refRunning || (lineDrop && locked_r))
    begin
      locked_r <= 1'b0;
      badCnt_r <= '0;
      goodCnt_r <= '0;
    end
    else if (rxLast)
    begin
      if (!badWord)
      begin
        badCnt_r <= '0;
        if (!locked_r && goodCnt_r == 3'(GOOD_LIMIT - 1))
          locked_r <= 1'b1;
        else if (!locked_r)
          goodCnt_r <= goodCnt_r + 3'd1;
      end
      else
      begin
        goodCnt_r <= '0;
        if (locked_r && badCnt_r == 3'(LOSS_LIMIT - 1))
        begin
          locked_r <= 1'b0;
          badCnt_r <= '0;
        end
        else if (locked_r)
          badCnt_r <= badCnt_r + 3'd1;
      end
    end
  end

  // Words go out through the buffer only while locked
  word_buffer #(
    .WIDTH(WORD_W)
  ) u_buf (
    .clk(clk),
    .resetn(resetn),
    .inValid(rxWordDone && locked_r),
    .inReady(),
    .inData(rxFrame[FRAME_W-2:1]),
    .outValid(parallelOutputValid),
    .outReady(parallelOutputReady),
    .outData(parallelOutputWord)
  );

  // Output pins registered
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lock_n <= 1'b1;
      parallelOutputOe <= 1'b0;
    end
    else
    begin
      lock_n <= !locked_r;
      parallelOutputOe <= locked_r;
    end
  end

  // With the line driven and the reference clock running, lock is lost only at the fourth bad word in a row
  chk_loss_after_four: assert property (
    @(posedge clk) disable iff (!resetn)
    (locked_r && badWord && refRunning && !lineDrop && badCnt_r < 3'(LOSS_LIMIT - 1))
    |=> locked_r)
    else $error("lock dropped before four bad words");

  // Lock indicator follows internal lock one cycle later
  chk_lock_pin: assert property (
    @(posedge clk) disable iff (!resetn)
    1'b1 |=> lock_n == !$past(locked_r))
    else $error("lock indicator wrong");

  // Outputs float while unlocked
  chk_out_float: assert property (
    @(posedge clk) disable iff (!resetn)
    lock_n |-> !parallelOutputOe)
    else $error("outputs driven while unlocked");

  // Serial output off when disabled
  chk_tx_float: assert property (
    @(posedge clk) disable iff (!resetn)
    !serialOutputEnable |=> !serialOutOe)
    else $error("serial driven while disabled");

  // A sync request keeps the symbol counter loaded
  chk_sync_count: assert property (
    @(posedge clk) disable iff (!resetn)
    syncAny && powerDown_n ##1 powerDown_n |-> syncLeft_r != '0)
    else $error("sync request lost");

  // No lock survives a stopped reference clock
  chk_ref_lock: assert property (
    @(posedge clk) disable iff (!resetn)
    !refRunning |=> !locked_r)
    else $error("locked without reference clock");
endmodule

//--- testbench/link_peer.sv
// Purpose: Peer serializer that drives the receive serial pins
// Assumes: Each bit lasts BIT_CYCLES core cycles
// Notes: An undriven line shows equal legs that toggle every cycle
`timescale 1ns/1ps
module link_peer
  import serdes_link_pkg::*;
(
  // Core clock
  input wire logic clk,
  // Serial line
  output logic serialPos,
  output logic serialNeg
);
  logic floatLine = 1'b1;
  // Start undriven
  initial
  begin
    serialPos = 1'b0;
    serialNeg = 1'b0;
  end
  // Undriven line: equal legs that toggle every cycle
  always @(posedge clk)
  begin
    if (floatLine)
    begin
      #2;
      serialPos = ~serialPos;
      serialNeg = serialPos;
    end
  end
  // Low bit, then one frame LSB first; stop of 1 is a bad clock bit
  task automatic send_frame(input logic [WORD_W-1:0] d,
                            input logic stopBit);
    logic [FRAME_W:0] f;
    f = {stopBit, d, START_BIT, 1'b0};
    floatLine = 1'b0;
    for (int i = 0; i <= FRAME_W; i++)
    begin
      @(posedge clk);
      #2;
      serialPos = f[i];
      serialNeg = ~f[i];
      repeat (BIT_CYCLES - 1) @(posedge clk);
    end
  endtask
endmodule

//--- testbench/tb_top.sv
// Purpose: Self-checking bench for the link lock and sync block
// Assumes: 40 MHz core clock; word and reference clocks of 200 ns
// Notes: The peer model drives the receive pins
`timescale 1ns/1ps
module tb_top import serdes_link_pkg::*;;
  logic clk, resetn, wordClk, receiver_reference_clock, refRun, syncA, syncB;
  logic outEn, pdN, rdy, sPos, sNeg, sOe, rxPos, rxNeg, pOe, pValid, lockN;
  logic [WORD_W-1:0] word;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  // Clocks: core, word, and a reference that can stop
  always #12.5 clk = ~clk;
  always #100 wordClk = ~wordClk;
  always #100 receiver_reference_clock = refRun ? ~receiver_reference_clock : receiver_reference_clock;
  link_peer peer_u (.clk(clk), .serialPos(rxPos), .serialNeg(rxNeg));
  serdes_link_lock_sync dut_u (
    .clk(clk), .resetn(resetn), .transmitWordClock(wordClk),
    .captureEdgeSelect(1'b1), .txWord(10'h000), .syncRequestA(syncA),
    .syncRequestB(syncB), .serialOutputEnable(outEn),
    .powerDown_n(pdN), .serialOutPos(sPos), .serialOutNeg(sNeg),
    .serialOutOe(sOe), .serialInPos(rxPos), .serialInNeg(rxNeg),
    .receiverReferenceClock(receiver_reference_clock), .parallelOutputWord(word),
    .parallelOutputOe(pOe), .parallelOutputValid(pValid),
    .parallelOutputReady(rdy), .lock_n(lockN));
  // Verdict and end of run
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Word compare
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Single bit compare
  task automatic chkb(input logic got, input logic exp);
    chk({11'h000, got}, {11'h000, exp});
  endtask
  // Wait n cycles, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Send sync frames until lock, bounded
  task automatic lock_up;
    for (int n = 0; n < 12 && lockN !== 1'b0; n++)
      peer_u.send_frame(SYNC_PATTERN, STOP_BIT);
    tick(10);
  endtask
  // Check the standing word; the next edge hands it over
  task automatic get_word(input logic [WORD_W-1:0] e);
    for (int n = 0; n < 300 && pValid !== 1'b1; n++)
      tick(1);
    chkb(pValid, 1'b1);
    chk({2'b00, word}, {2'b00, e});
    tick(1);
  endtask
  // Find a start edge, then sample 12 bits
  task automatic read_frame(input logic [11:0] e);
    logic [11:0] f;
    f = 12'h001;
    for (int n = 0; n < 200 && !(sPos === 1'b1 && f[0] === 1'b0); n++)
    begin
      f[0] = sPos;
      tick(1);
    end
    for (int i = 0; i < FRAME_W; i++)
    begin
      f[i] = sPos;
      chkb(sNeg, ~sPos);
      tick(BIT_CYCLES);
    end
    chk(f, e);
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_mismatch++;
      give_verdict;
    end
  end
  // Main sequence
  initial
  begin
    clk = 1'b0; resetn = 1'b0; wordClk = 1'b0; receiver_reference_clock = 1'b0;
    refRun = 1'b0; syncA = 1'b0; syncB = 1'b0; outEn = 1'b1;
    pdN = 1'b1; rdy = 1'b1;
    tick(5);
    resetn = 1'b1;
    tick(2);
    chkb(lockN, 1'b1);
    chkb(pOe, 1'b0);
    // No reference clock: no lock
    repeat (6) peer_u.send_frame(SYNC_PATTERN, STOP_BIT);
    tick(10);
    chkb(lockN, 1'b1);
    refRun = 1'b1;
    lock_up;
    chkb(lockN, 1'b0);
    chkb(pOe, 1'b1);
    // Receiver stalls over two words, then drains them in order
    tick(60);
    rdy = 1'b0;
    peer_u.send_frame(10'h2a5, STOP_BIT);
    peer_u.send_frame(10'h15a, STOP_BIT);
    tick(60);
    rdy = 1'b1;
    get_word(10'h2a5);
    get_word(10'h15a);
    // Three bad frames then a good one keep lock
    repeat (3) peer_u.send_frame(SYNC_PATTERN, ~STOP_BIT);
    peer_u.send_frame(SYNC_PATTERN, STOP_BIT);
    tick(20);
    chkb(lockN, 1'b0);
    repeat (4) peer_u.send_frame(SYNC_PATTERN, ~STOP_BIT);
    tick(20);
    chkb(lockN, 1'b1);
    lock_up;
    chkb(lockN, 0);
    peer_u.floatLine = 1'b1;
    tick(300);
    chkb(lockN, 1'b1);
    // Short request still gives a long sync run
    syncB = 1'b1;
    tick(10);
    syncB = 1'b0;
    read_frame({STOP_BIT, SYNC_PATTERN, START_BIT});
    tick(45000);
    read_frame({STOP_BIT, SYNC_PATTERN, START_BIT});
    tick(5000);
    read_frame({STOP_BIT, 10'h000, START_BIT});
    syncA = lockN;
    tick(100);
    read_frame({STOP_BIT, SYNC_PATTERN, START_BIT});
    syncA = 1'b0;
    outEn = 1'b0;
    tick(8);
    chkb(sOe, 1'b0);
    outEn = 1'b1;
    pdN = 1'b0;
    tick(8);
    chkb(sOe, 1'b0);
    give_verdict;
  end
endmodule
